// *** transcoder_serial_port_control.sv ***
/*
  Second PCM serial stream of a voice transcoder with its channel strobes,
  delayed frame pulse, slot steering, coding selection and power-down, plus
  a small register port. Assumes ref_clk for the register side and the
  backplane master clock for the link; every pin is synchronised first.
*/
`timescale 1ns/1ps
module transcoder_serial_port_control (
  // Register side clock and reset.
  input wire logic ref_clk,
  input wire logic rst,
  // Register port.
  input wire logic [transcoder_pkg::ADDR_W-1:0] addr,
  input wire logic [transcoder_pkg::DATA_W-1:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [transcoder_pkg::DATA_W-1:0] rdata,
  // Link clock and control pins.
  input wire logic backplane_master_clock,
  input wire logic power_down_n,
  input wire logic frame_pulse_in,
  input wire logic bit_clk_in,
  input wire logic internal_tie_input,
  // Channel strobes and the shared strobe/frame pin.
  input wire logic first_channel_strobe_in,
  input wire logic second_channel_strobe_in,
  output logic delayed_frame_pulse_out,
  output logic frame_pulse_oe_n,
  // Second PCM stream.
  input wire logic pcm_stream_two_in,
  output logic pcm_stream_two_out,
  output logic pcm_stream_two_oe_n
);

  localparam int W = transcoder_pkg::WORD_W;

  // Register side state.
  transcoder_pkg::ctrl_t ctrl_q;
  logic [W-1:0] rx_data_q;
  logic rx_valid_q;
  logic [transcoder_pkg::DATA_W-1:0] rdata_q, rd_mux;
  logic [2:0] st_s1_q, st_s2_q;
  logic tx_push, tx_busy, rx_arrive;
  logic [W-1:0] rx_arrive_data;
  transcoder_pkg::status_t status;

  // Link side state.
  logic [transcoder_pkg::PIN_W-1:0] pins, pin_s1_q, pin_s2_q;
  transcoder_pkg::ctrl_t ctrl_s1_q, ctrl_s2_q;
  transcoder_pkg::link_state_t state_q, state_d;
  logic fp_prev_q, bclk_prev_q, run_q, fp_out_q;
  logic [3:0] low_cnt_q, in_bit_q, out_bit_q, in_idx, out_idx, last_bit;
  logic [8:0] cyc_q, fp_hit;
  logic [2:0] in_slot_q, out_slot_q, slot, rx_slot, tx_slot;
  logic [4:0] word_idx;
  logic pd_n_s, fp_s, bclk_s, stb1_s, stb2_s, din_s;
  logic frame_start, sample_ev, shift_ev, tx_en;
  logic [W-1:0] rx_sh_q, tx_sh_q, rx_word_q, tx_word_q, rx_word, tx_word, tx_coded;
  logic [W-1:0] dc_q [2];
  logic rx_done_q, out_q, oe_n_q, tx_arrive;
  logic [W-1:0] tx_arrive_data;

  // Applies the selected telephony coding to a sign-magnitude byte.
  function automatic logic [7:0] code_byte(input transcoder_pkg::ctrl_t c,
                                           input logic [7:0] b);
    logic [7:0] mask;
    mask = c.law_sel ? transcoder_pkg::ALAW_ITU_MASK : transcoder_pkg::MULAW_ITU_MASK;
    code_byte = c.format_sel ? (b ^ mask) : b;
  endfunction

  // Slot that carries this stream's sample in a given mode.
  function automatic logic [2:0] pick_slot(input logic [2:0] mode, input logic port,
                                           input logic is_out);
    pick_slot = transcoder_pkg::SLOT_B2;
    if (mode == transcoder_pkg::MODE_ADPCM16) begin
      pick_slot = port ? transcoder_pkg::SLOT_B2 : transcoder_pkg::SLOT_B1;
    end else if (mode == transcoder_pkg::MODE_PCM_BYPASS && !port) begin
      pick_slot = transcoder_pkg::SLOT_NONE;
    end else if (is_out && mode == transcoder_pkg::MODE_OUT_DISABLE) begin
      pick_slot = transcoder_pkg::SLOT_NONE;
    end
  endfunction

  // ---------------- Register side ----------------

  // Control register, written by software.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctrl_q <= transcoder_pkg::CTRL_RESET;
    end else if (wr_en && addr == transcoder_pkg::CTRL_OFS) begin
      ctrl_q <= wdata[transcoder_pkg::CTRL_W-1:0];
    end
  end

  // Received word and its sticky flag; a new arrival beats a read clear.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rx_data_q <= '0;
      rx_valid_q <= 1'b0;
    end else if (rx_arrive) begin
      rx_data_q <= rx_arrive_data;
      rx_valid_q <= 1'b1;
    end else if (rd_en && addr == transcoder_pkg::RX_OFS) begin
      rx_valid_q <= 1'b0;
    end
  end

  // Link status levels brought over by two flip-flops.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_s1_q <= 3'h2;
      st_s2_q <= 3'h2;
    end else begin
      st_s1_q <= {pin_s2_q[transcoder_pkg::PIN_TIE], state_q == transcoder_pkg::LS_OFF,
                  state_q == transcoder_pkg::LS_STROBED};
      st_s2_q <= st_s1_q;
    end
  end

  assign tx_push = wr_en && addr == transcoder_pkg::TX_OFS && !tx_busy;
  assign status = '{tie_high: st_s2_q[2], offline: st_s2_q[1], strobed: st_s2_q[0],
                    tx_busy: tx_busy, rx_valid: rx_valid_q};

  // Read multiplexer; unmapped offsets read as zero.
  always_comb begin
    rd_mux = '0;
    case (addr)
      transcoder_pkg::CTRL_OFS: rd_mux[transcoder_pkg::CTRL_W-1:0] = ctrl_q;
      transcoder_pkg::STATUS_OFS: rd_mux[transcoder_pkg::STATUS_W-1:0] = status;
      transcoder_pkg::RX_OFS: rd_mux[W-1:0] = rx_data_q;
      default: rd_mux = '0;
    endcase
  end

  // Read data stand for exactly the cycle after the strobe.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rd_en ? rd_mux : '0;
    end
  end

  assign rdata = rdata_q;

  // Word crossings in both directions.
  pcm_word_sync #(.W(W)) tx_cross (
    .src_clk(ref_clk),
    .dst_clk(backplane_master_clock),
    .rst(rst),
    .src_valid(tx_push),
    .src_data(wdata[W-1:0]),
    .src_busy(tx_busy),
    .dst_valid(tx_arrive),
    .dst_data(tx_arrive_data)
  );

  pcm_word_sync #(.W(W)) rx_cross (
    .src_clk(backplane_master_clock),
    .dst_clk(ref_clk),
    .rst(rst),
    .src_valid(rx_done_q),
    .src_data(rx_word_q),
    .src_busy(),
    .dst_valid(rx_arrive),
    .dst_data(rx_arrive_data)
  );

  // ---------------- Link side ----------------

  assign pins = {internal_tie_input, pcm_stream_two_in, second_channel_strobe_in,
                 first_channel_strobe_in, bit_clk_in, frame_pulse_in, power_down_n};

  // Two-stage synchronisers for pins and control; reset reads as powered down.
  always_ff @(posedge backplane_master_clock or posedge rst) begin
    if (rst) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
      ctrl_s1_q <= transcoder_pkg::CTRL_RESET;
      ctrl_s2_q <= transcoder_pkg::CTRL_RESET;
    end else begin
      pin_s1_q <= pins;
      pin_s2_q <= pin_s1_q;
      ctrl_s1_q <= ctrl_q;
      ctrl_s2_q <= ctrl_s1_q;
    end
  end

  assign pd_n_s = pin_s2_q[transcoder_pkg::PIN_PD_N];
  assign fp_s = pin_s2_q[transcoder_pkg::PIN_FP];
  assign bclk_s = pin_s2_q[transcoder_pkg::PIN_BCLK];
  assign stb1_s = pin_s2_q[transcoder_pkg::PIN_STB1];
  assign stb2_s = pin_s2_q[transcoder_pkg::PIN_STB2];
  assign din_s = pin_s2_q[transcoder_pkg::PIN_DIN];

  // Edge history and the count of frame pulse low time.
  always_ff @(posedge backplane_master_clock or posedge rst) begin
    if (rst) begin
      fp_prev_q <= 1'b1;
      bclk_prev_q <= 1'b0;
      low_cnt_q <= 4'h0;
    end else begin
      fp_prev_q <= fp_s;
      bclk_prev_q <= bclk_s;
      if (fp_s) begin
        low_cnt_q <= 4'h0;
      end else if (low_cnt_q != transcoder_pkg::STROBED_LOW_LIMIT) begin
        low_cnt_q <= low_cnt_q + 4'h1;
      end
    end
  end

  // Operating state: off while powered down, strobed while the pulse stays low.
  always_comb begin
    state_d = state_q;
    case (state_q)
      transcoder_pkg::LS_OFF: begin
        if (pd_n_s) state_d = transcoder_pkg::LS_TDM;
      end
      transcoder_pkg::LS_TDM: begin
        if (!pd_n_s) state_d = transcoder_pkg::LS_OFF;
        else if (low_cnt_q == transcoder_pkg::STROBED_LOW_LIMIT) begin
          state_d = transcoder_pkg::LS_STROBED;
        end
      end
      transcoder_pkg::LS_STROBED: begin
        if (!pd_n_s) state_d = transcoder_pkg::LS_OFF;
        else if (fp_s) state_d = transcoder_pkg::LS_TDM;
      end
      default: state_d = transcoder_pkg::LS_OFF;
    endcase
  end

  always_ff @(posedge backplane_master_clock or posedge rst) begin
    if (rst) begin
      state_q <= transcoder_pkg::LS_OFF;
    end else begin
      state_q <= state_d;
    end
  end

  assign frame_start = state_q == transcoder_pkg::LS_TDM && fp_prev_q && !fp_s;

  // Master cycle count within the backplane frame.
  always_ff @(posedge backplane_master_clock or posedge rst) begin
    if (rst) begin
      cyc_q <= 9'h000;
      run_q <= 1'b0;
    end else if (state_q != transcoder_pkg::LS_TDM) begin
      cyc_q <= 9'h000;
      run_q <= 1'b0;
    end else if (frame_start) begin
      cyc_q <= 9'h000;
      run_q <= 1'b1;
    end else begin
      cyc_q <= cyc_q + 9'h001;
    end
  end

  // Delayed frame pulse, active low, one master cycle wide.
  assign fp_hit = ctrl_s2_q.linear_sel ? transcoder_pkg::FP_HIT_LINEAR
                                       : transcoder_pkg::FP_HIT_COMPANDED;
  always_ff @(posedge backplane_master_clock or posedge rst) begin
    if (rst) begin
      fp_out_q <= 1'b1;
    end else begin
      fp_out_q <= !(run_q && !frame_start && cyc_q == fp_hit);
    end
  end

  assign delayed_frame_pulse_out = fp_out_q;
  assign frame_pulse_oe_n = state_q != transcoder_pkg::LS_TDM;

  // Bit events and the slot under way in either mode.
  assign last_bit = ctrl_s2_q.linear_sel ? transcoder_pkg::LIN_LAST_BIT
                                         : transcoder_pkg::COMP_LAST_BIT;
  assign word_idx = ctrl_s2_q.linear_sel ? {1'b0, cyc_q[8:5]} : cyc_q[8:4];
  always_comb begin
    sample_ev = 1'b0;
    shift_ev = 1'b0;
    slot = transcoder_pkg::SLOT_NONE;
    if (state_q == transcoder_pkg::LS_STROBED) begin
      sample_ev = bclk_prev_q && !bclk_s;
      shift_ev = !bclk_prev_q && bclk_s;
      if (stb2_s) slot = transcoder_pkg::SLOT_B2;
      else if (stb1_s) slot = transcoder_pkg::SLOT_B1;
    end else if (run_q && !frame_start) begin
      sample_ev = cyc_q[0];
      shift_ev = !cyc_q[0];
      if (word_idx < 5'h04) slot = word_idx[2:0];
    end
  end

  assign rx_slot = pick_slot(ctrl_s2_q.enc_mode, ctrl_s2_q.port_sel, 1'b0);
  assign tx_slot = pick_slot(ctrl_s2_q.dec_mode, ctrl_s2_q.port_sel, 1'b1);
  assign in_idx = (slot == in_slot_q) ? in_bit_q : 4'h0;
  assign out_idx = (slot == out_slot_q) ? out_bit_q : 4'h0;
  assign rx_word = ctrl_s2_q.linear_sel ? {rx_sh_q[W-2:0], din_s}
                                        : {rx_sh_q[6:0], din_s, 8'h00};

  // Receive shifter: words of the chosen slot go to software, D and C are kept.
  always_ff @(posedge backplane_master_clock or posedge rst) begin
    if (rst) begin
      rx_sh_q <= '0;
      in_bit_q <= 4'h0;
      in_slot_q <= transcoder_pkg::SLOT_NONE;
      rx_word_q <= '0;
      rx_done_q <= 1'b0;
      dc_q[0] <= '0;
      dc_q[1] <= '0;
    end else begin
      rx_done_q <= 1'b0;
      if (state_q == transcoder_pkg::LS_OFF) begin
        in_bit_q <= 4'h0;
        in_slot_q <= transcoder_pkg::SLOT_NONE;
      end else if (sample_ev) begin
        rx_sh_q <= {rx_sh_q[W-2:0], din_s};
        in_slot_q <= slot;
        in_bit_q <= (in_idx == last_bit) ? 4'h0 : in_idx + 4'h1;
        if (in_idx == last_bit && slot != transcoder_pkg::SLOT_NONE) begin
          if (slot == rx_slot) begin
            rx_word_q <= ctrl_s2_q.linear_sel ? rx_word
                         : {code_byte(ctrl_s2_q, rx_word[15:8]), 8'h00};
            rx_done_q <= 1'b1;
          end
          if (state_q == transcoder_pkg::LS_TDM && slot[1]) begin
            dc_q[slot[0]] <= rx_word;
          end
        end
      end
    end
  end

  // Latest word from software, coded for the line.
  always_ff @(posedge backplane_master_clock or posedge rst) begin
    if (rst) begin
      tx_word_q <= '0;
    end else if (tx_arrive) begin
      tx_word_q <= tx_arrive_data;
    end
  end

  assign tx_coded = ctrl_s2_q.linear_sel ? tx_word_q
                    : {code_byte(ctrl_s2_q, tx_word_q[15:8]), 8'h00};

  // Choose what this slot drives: the sample, passed D and C, or nothing.
  always_comb begin
    tx_en = 1'b0;
    tx_word = tx_coded;
    if (slot != transcoder_pkg::SLOT_NONE && slot == tx_slot) begin
      tx_en = 1'b1;
    end else if (state_q == transcoder_pkg::LS_TDM && slot[1] && !slot[2]) begin
      tx_en = !stb1_s;
      tx_word = dc_q[slot[0]];
    end
  end

  // Transmit shifter, MSB first, with the pin floating outside its slots.
  always_ff @(posedge backplane_master_clock or posedge rst) begin
    if (rst) begin
      tx_sh_q <= '0;
      out_bit_q <= 4'h0;
      out_slot_q <= transcoder_pkg::SLOT_NONE;
      out_q <= 1'b0;
      oe_n_q <= 1'b1;
    end else if (state_q == transcoder_pkg::LS_OFF) begin
      out_bit_q <= 4'h0;
      out_slot_q <= transcoder_pkg::SLOT_NONE;
      oe_n_q <= 1'b1;
    end else if (shift_ev) begin
      out_slot_q <= slot;
      out_bit_q <= (out_idx == last_bit) ? 4'h0 : out_idx + 4'h1;
      oe_n_q <= !tx_en;
      if (out_idx == 4'h0) begin
        out_q <= tx_word[W-1];
        tx_sh_q <= {tx_word[W-2:0], 1'b0};
      end else begin
        out_q <= tx_sh_q[W-1];
        tx_sh_q <= {tx_sh_q[W-2:0], 1'b0};
      end
    end
  end

  assign pcm_stream_two_out = out_q;
  assign pcm_stream_two_oe_n = oe_n_q | (state_q == transcoder_pkg::LS_OFF);

endmodule // transcoder_serial_port_control

// *** transcoder_pkg.sv ***
/*
  Shared constants and types for the serial port control block of a
  four-channel voice transcoder: register map, control layout, mode codes,
  slot numbers, pin synchroniser positions and frame timing counts.
  Assumes nothing of its surroundings; it holds definitions only.
*/
package transcoder_pkg;

  // Register bus widths and byte offsets.
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] TX_OFS = 8'h08;
  localparam logic [7:0] RX_OFS = 8'h0C;

  // Sample words are carried left aligned in this width.
  localparam int WORD_W = 16;

  // Control register layout, bit 0 upward: law, format, linear, port select.
  typedef struct packed {
    logic [2:0] dec_mode;
    logic [2:0] enc_mode;
    logic port_sel;
    logic linear_sel;
    logic format_sel;
    logic law_sel;
  } ctrl_t;
  localparam int CTRL_W = 10;
  localparam logic [9:0] CTRL_RESET = 10'h000;

  // Status register layout, bit 0 upward.
  typedef struct packed {
    logic tie_high;
    logic offline;
    logic strobed;
    logic tx_busy;
    logic rx_valid;
  } status_t;
  localparam int STATUS_W = 5;

  // Mode select codes that steer this port.
  localparam logic [2:0] MODE_ADPCM16 = 3'h2;
  localparam logic [2:0] MODE_PCM_BYPASS = 3'h5;
  localparam logic [2:0] MODE_OUT_DISABLE = 3'h7;

  // Slot identities on the stream; the backplane word index equals the id.
  localparam logic [2:0] SLOT_B1 = 3'h0;
  localparam logic [2:0] SLOT_B2 = 3'h1;
  localparam logic [2:0] SLOT_D = 3'h2;
  localparam logic [2:0] SLOT_C = 3'h3;
  localparam logic [2:0] SLOT_NONE = 3'h4;

  // Positions in the pin synchroniser vector.
  localparam int PIN_PD_N = 0;
  localparam int PIN_FP = 1;
  localparam int PIN_BCLK = 2;
  localparam int PIN_STB1 = 3;
  localparam int PIN_STB2 = 4;
  localparam int PIN_DIN = 5;
  localparam int PIN_TIE = 6;
  localparam int PIN_W = 7;

  // Frame timing in master clock cycles.
  localparam int SYNC_LAT = 2;
  localparam int FP_DELAY_COMPANDED = 64;
  localparam int FP_DELAY_LINEAR = 128;
  localparam logic [8:0] FP_HIT_COMPANDED = 9'(FP_DELAY_COMPANDED - SYNC_LAT - 1);
  localparam logic [8:0] FP_HIT_LINEAR = 9'(FP_DELAY_LINEAR - SYNC_LAT - 1);
  localparam logic [3:0] STROBED_LOW_LIMIT = 4'h8;
  localparam logic [3:0] COMP_LAST_BIT = 4'h7;
  localparam logic [3:0] LIN_LAST_BIT = 4'hF;

  // Telephony coding masks applied to sign-magnitude bytes.
  localparam logic [7:0] ALAW_ITU_MASK = 8'h55;
  localparam logic [7:0] MULAW_ITU_MASK = 8'h7F;

  // Link operating state, one-hot.
  typedef enum logic [2:0] {
    LS_OFF = 3'b001,
    LS_STROBED = 3'b010,
    LS_TDM = 3'b100
  } link_state_t;

endpackage

// *** pcm_word_sync.sv ***
/*
  Word crossing between two clock domains by a toggle request and a toggle
  acknowledge. Assumes the source holds off while busy is high; a word
  offered while busy is not taken.
*/
`timescale 1ns/1ps
module pcm_word_sync #(
  parameter int W = 16
) (
  // Clocks and reset.
  input wire logic src_clk,
  input wire logic dst_clk,
  input wire logic rst,
  // Source side.
  input wire logic src_valid,
  input wire logic [W-1:0] src_data,
  output logic src_busy,
  // Destination side.
  output logic dst_valid,
  output logic [W-1:0] dst_data
);

  logic req_q, ack_s1_q, ack_s2_q;
  logic req_s1_q, req_s2_q, req_s3_q, valid_q;
  logic [W-1:0] hold_q, dst_data_q;

  // Source holds the word and flips the request while no crossing is open.
  always_ff @(posedge src_clk or posedge rst) begin
    if (rst) begin
      req_q <= 1'b0;
      hold_q <= '0;
      ack_s1_q <= 1'b0;
      ack_s2_q <= 1'b0;
    end else begin
      ack_s1_q <= req_s3_q;
      ack_s2_q <= ack_s1_q;
      if (src_valid && !src_busy) begin
        hold_q <= src_data;
        req_q <= ~req_q;
      end
    end
  end

  assign src_busy = req_q ^ ack_s2_q;

  // Destination copies the stable word once the request has settled.
  // Valid is registered so that it rises in the same cycle as the copied word.
  always_ff @(posedge dst_clk or posedge rst) begin
    if (rst) begin
      req_s1_q <= 1'b0;
      req_s2_q <= 1'b0;
      req_s3_q <= 1'b0;
      valid_q <= 1'b0;
      dst_data_q <= '0;
    end else begin
      req_s1_q <= req_q;
      req_s2_q <= req_s1_q;
      req_s3_q <= req_s2_q;
      valid_q <= req_s2_q != req_s3_q;
      if (req_s2_q != req_s3_q) begin
        dst_data_q <= hold_q;
      end
    end
  end

  assign dst_valid = valid_q;
  assign dst_data = dst_data_q;

endmodule // pcm_word_sync

// *** transcoder_serial_port_control_assertions.sv ***
/* Checker for the serial port control block.
   Sees only the top ports; the testbench binds it to the design. */
`timescale 1ns/1ps
module port_ctrl_checker (
  // Clocks and reset.
  input wire logic ref_clk,
  input wire logic backplane_master_clock,
  input wire logic rst,
  // Register read side.
  input wire logic [7:0] addr,
  input wire logic rd_en,
  input wire logic [31:0] rdata,
  // Link pins.
  input wire logic power_down_n,
  input wire logic frame_pulse_in,
  input wire logic delayed_frame_pulse_out,
  input wire logic frame_pulse_oe_n,
  input wire logic pcm_stream_two_out,
  input wire logic pcm_stream_two_oe_n
);
  logic fp_q;
  logic [7:0] fp_age_q;
  logic [4:0] fp_low_q;
  // Cycles since the frame pulse fell and cycles it stayed low, both saturating.
  always_ff @(posedge backplane_master_clock or posedge rst) begin
    if (rst) begin
      fp_q <= 1'b1;
      fp_age_q <= 8'hFF;
      fp_low_q <= 5'h00;
    end else begin
      fp_q <= frame_pulse_in;
      fp_age_q <= (fp_q && !frame_pulse_in) ? 8'h00 : fp_age_q + {7'h00, fp_age_q != 8'hFF};
      fp_low_q <= frame_pulse_in ? 5'h00 : fp_low_q + {4'h0, fp_low_q != 5'h1F};
    end
  end
  sequence pd_held;
    !power_down_n [*4];
  endsequence
  sequence pulse_fall;
    $fell(delayed_frame_pulse_out);
  endsequence
  a_rdata_idle: assert property (@(posedge ref_clk) disable iff (rst)
    !$past(rd_en) |-> rdata == 32'h0) else $error("read data out of slot");
  a_unmapped_zero: assert property (@(posedge ref_clk) disable iff (rst)
    rd_en && addr == 8'h40 |=> rdata == 32'h0) else $error("unmapped read not zero");
  a_pd_float: assert property (@(posedge backplane_master_clock) disable iff (rst)
    pd_held |-> pcm_stream_two_oe_n && frame_pulse_oe_n) else $error("driven in power-down");
  a_pulse_width: assert property (@(posedge backplane_master_clock) disable iff (rst)
    pulse_fall |=> delayed_frame_pulse_out) else $error("frame pulse too wide");
  a_pulse_delay: assert property (@(posedge backplane_master_clock) disable iff (rst)
    pulse_fall |-> fp_age_q inside {[62:66], [126:130]}) else $error("frame pulse delay");
  a_pulse_driven: assert property (@(posedge backplane_master_clock) disable iff (rst)
    !delayed_frame_pulse_out |-> !frame_pulse_oe_n) else $error("pulse on floating pin");
  a_strobed_input: assert property (@(posedge backplane_master_clock) disable iff (rst)
    fp_low_q == 5'h1F |-> frame_pulse_oe_n) else $error("shared pin driven in strobed mode");
  a_bit_hold: assert property (@(posedge backplane_master_clock) disable iff (rst)
    !frame_pulse_oe_n && !pcm_stream_two_oe_n && $changed(pcm_stream_two_out)
    |=> $stable(pcm_stream_two_out) || pcm_stream_two_oe_n) else $error("short output bit");
endmodule // port_ctrl_checker

// *** pcm_codec_model.sv ***
/* Codec and backplane framer model facing the second PCM stream.
   Runs on the master clock; the bench picks strobed or backplane mode. */
`timescale 1ns/1ps
module pcm_codec_model (
  // Master clock and mode.
  input wire logic mclk,
  input wire logic strobed,
  // Pins toward the device.
  output logic fp_n,
  output logic bclk,
  output logic stb1,
  output logic stb2,
  output logic din,
  // Device stream and the last word taken from the B2 slot.
  input wire logic dout,
  input wire logic dout_oe_n,
  output logic [7:0] got
);
  localparam logic [7:0] RX_WORD = 8'h5A;
  logic [8:0] cnt = 9'h000;
  logic [7:0] sh = 8'h00;
  initial {fp_n, bclk, stb1, stb2, din, got} = {5'h10, 8'h00};
  // Frames of 512 cycles; a strobed frame holds 64 bit cells of 8 cycles.
  always @(posedge mclk) begin
    cnt <= cnt + 9'h001;
    fp_n <= !strobed && cnt != 9'h1FF;
    bclk <= strobed && !cnt[2];
    stb1 <= strobed && cnt[7:6] == 2'h0;
    stb2 <= strobed && cnt[7:6] == 2'h1;
    // Outside the slot the line keeps changing, so stale data never matches.
    // On the backplane the B2 bits change every two cycles, two cycles ahead of the device.
    if (!strobed && cnt[8:4] == 5'h01) din <= RX_WORD[~cnt[3:1]];
    else if (cnt[2:0] == 3'h0) din <= (cnt[7:6] == 2'h1) ? RX_WORD[~cnt[5:3]] : !din;
    // A floating stream reads as the inverse of its last bit.
    if (strobed && cnt[7:6] == 2'h1 && cnt[2:0] == 3'h7) begin
      sh <= {sh[6:0], dout ^ dout_oe_n};
      if (cnt[5:3] == 3'h7 && !dout_oe_n) got <= {sh[6:0], dout};
    end
  end
endmodule // pcm_codec_model

// *** transcoder_serial_port_control_test.sv ***
/* Self-checking bench for the serial port control block.
   Drives the register port and pins; a codec model sits on the stream. */
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin error_cnt++; $display("mismatch %s expected %h seen %h", n, e, g); end end
module transcoder_serial_port_control_test;
  logic ref_clk = 1'b0;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic pd_n = 1'b0;
  logic strobed = 1'b0;
  logic dc_float = 1'b0;
  logic [31:0] rdata;
  logic [7:0] got;
  logic fp_n, bclk, stb1, stb2, din, dfpo, fp_oe_n, dout, dout_oe_n;
  wire logic pin2 = fp_oe_n ? stb2 : dfpo;
  int error_cnt = 0;
  int checked = 0;
  // Register clock at 100 MHz and an unrelated 64 ns link clock.
  initial forever #5 ref_clk = ~ref_clk;
  initial begin
    #3;
    forever #32 mclk = ~mclk;
  end
  transcoder_serial_port_control uut (.ref_clk(ref_clk), .rst(rst), .addr(addr),
    .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
    .backplane_master_clock(mclk), .power_down_n(pd_n), .frame_pulse_in(fp_n),
    .bit_clk_in(bclk), .internal_tie_input(1'b1),
    .first_channel_strobe_in(strobed ? stb1 : dc_float), .second_channel_strobe_in(pin2),
    .delayed_frame_pulse_out(dfpo), .frame_pulse_oe_n(fp_oe_n), .pcm_stream_two_in(din),
    .pcm_stream_two_out(dout), .pcm_stream_two_oe_n(dout_oe_n));
  pcm_codec_model codec (.mclk(mclk), .strobed(strobed), .fp_n(fp_n), .bclk(bclk),
    .stb1(stb1), .stb2(stb2), .din(din), .dout(dout), .dout_oe_n(dout_oe_n), .got(got));
  task automatic stop_test();
    if (error_cnt == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge ref_clk);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    #1 d = rdata;
  endtask
  // Counts the master cycles of one frame in which the stream is driven.
  task automatic oe_count(output int n);
    n = 0;
    repeat (600) @(posedge mclk);
    repeat (512) begin
      @(posedge mclk);
      if (dout_oe_n === 1'b0) n++;
    end
  endtask
  // Measures master cycles from a frame pulse to the delayed pulse.
  task automatic fp_delay(output int d);
    int i;
    d = 0;
    repeat (1100) @(posedge mclk);
    for (i = 0; i < 600 && fp_n !== 1'b0; i++) @(posedge mclk);
    while (dfpo !== 1'b0 && d < 300) begin
      @(posedge mclk);
      d++;
    end
    if (d == 300 || i == 600) begin
      error_cnt++;
      stop_test();
    end
  endtask
  initial begin
    logic [31:0] v;
    logic [7:0] m;
    logic hit;
    int n;
    int i;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    repeat (4) @(posedge mclk);
    // Powered down: offline with the tie pin reported high.
    rd(8'h04, v);
    `CHK("status", 2'h3, v[4:3])
    rd(8'h40, v);
    // Backplane mode: pulse delay, D and C slots, bypass steering.
    @(posedge mclk) pd_n <= 1'b1;
    fp_delay(n);
    `CHK("fp_delay", 1'b1, n inside {[63:65]})
    for (i = 0; i < 2; i++) begin
      @(posedge mclk) dc_float <= i[0];
      oe_count(n);
      `CHK("dc_slots", 48 - 32 * i, n)
    end
    for (i = 0; i < 3; i++) begin
      wr(8'h00, (i == 0) ? 32'h280 : (i == 1) ? 32'h288 : 32'h100);
      oe_count(n);
      `CHK("bypass", (i == 0) ? 0 : 16, n)
    end
    rd(8'h0C, v);
    `CHK("rx_tdm", 8'h5A, v[15:8])
    wr(8'h00, 32'h4);
    fp_delay(n);
    `CHK("fp_delay_lin", 1'b1, n inside {[127:129]})
    // Strobed mode: words cross both ways under each coding choice.
    @(posedge mclk) strobed <= 1'b1;
    wr(8'h00, 32'h0);
    repeat (600) @(posedge mclk);
    rd(8'h04, v);
    `CHK("strobed", 1'b1, v[2])
    for (i = 0; i < 3; i++) begin
      m = (i == 0) ? 8'h00 : (i == 1) ? 8'h55 : 8'h7F;
      wr(8'h00, (i == 0) ? 32'h0 : (i == 1) ? 32'h3 : 32'h2);
      wr(8'h08, 32'h3C00);
      hit = 1'b0;
      repeat (1024) begin
        @(posedge mclk);
        if (got === (8'h3C ^ m)) hit = 1'b1;
      end
      `CHK("tx_word", 1'b1, hit)
      rd(8'h0C, v);
      `CHK("rx_word", 8'h5A ^ m, v[15:8])
    end
    // Power-down floats every output again.
    @(posedge mclk) pd_n <= 1'b0;
    repeat (4) @(posedge mclk);
    `CHK("pd_oe", 2'h3, {fp_oe_n, dout_oe_n})
    stop_test();
  end
endmodule // transcoder_serial_port_control_test
bind transcoder_serial_port_control port_ctrl_checker chk (.ref_clk(ref_clk), .rst(rst),
  .backplane_master_clock(backplane_master_clock), .addr(addr), .rd_en(rd_en),
  .rdata(rdata), .power_down_n(power_down_n), .frame_pulse_in(frame_pulse_in),
  .delayed_frame_pulse_out(delayed_frame_pulse_out), .frame_pulse_oe_n(frame_pulse_oe_n),
  .pcm_stream_two_out(pcm_stream_two_out), .pcm_stream_two_oe_n(pcm_stream_two_oe_n));
